// [hw/sfc_pkg.sv]
// Shared constants for the serial nonvolatile memory command slave
package sfc_pkg;
    // Operation codes, sent most significant bit first
    localparam logic [7:0] OPC_SET_WE   = 8'h06;
    localparam logic [7:0] OPC_CLR_WE   = 8'h04;
    localparam logic [7:0] OPC_STAT_RD  = 8'h05;
    localparam logic [7:0] OPC_STAT_WR  = 8'h01;
    localparam logic [7:0] OPC_MEM_RD   = 8'h03;
    localparam logic [7:0] OPC_MEM_WR   = 8'h02;
    // Status register field positions
    localparam int STAT_IN_PROGRESS_BIT = 0;
    localparam int STAT_WEL_BIT         = 1;
    localparam int STAT_SEL0_BIT        = 2;
    localparam int STAT_SEL1_BIT        = 3;
    localparam int STAT_LOCK_BIT        = 7;
    // Reset values of the volatile status fields
    localparam logic RST_WRITE_ENABLE   = 1'b0;
    localparam logic RST_PROTECT_SEL    = 1'b0;
    localparam logic RST_STATUS_LOCK    = 1'b0;
    // Array geometry, serial address and sampler widths
    localparam int MEM_AW               = 12;
    localparam int MEM_DEPTH            = 4096;
    localparam int SPI_AW               = 16;
    localparam int SYNC_W               = 5;
    // Input sampler bit positions
    localparam int PIN_CS               = 0;
    localparam int PIN_SCK              = 1;
    localparam int PIN_SI               = 2;
    localparam int PIN_PAUSE            = 3;
    localparam int PIN_WP               = 4;
    // Protocol states, one-hot
    typedef enum logic [6:0] {
        ST_OPC     = 7'b000_0001,
        ST_ADDR    = 7'b000_0010,
        ST_MEM_RD  = 7'b000_0100,
        ST_MEM_WR  = 7'b000_1000,
        ST_STAT_RD = 7'b001_0000,
        ST_STAT_WR = 7'b010_0000,
        ST_IGNORE  = 7'b100_0000
    } sfc_state_e;
endpackage : sfc_pkg

// [hw/sfc_top.sv]
// Serial command slave for a 4096 x 8 nonvolatile memory, pins sampled on the system clock
//
// Notes on behaviour
// - Sample input on rise, shift output on fall
// - Works in clock modes zero and three
// - Pause tristates output, freezes clock and input
// - Select fall starts command; data only selected
// - First byte is opcode; enable, disable, status read
// - Opcodes for status write, memory read, write
// - Unknown opcode ignores rest until reselect
// - Status shows latch; other fixed bits zero
// - Lock bit plus protect pin blocks status writes
// - Status is volatile; host reprograms after power-on
// - Set-enable command sets the latch
// - Writes take effect only with latch set
// - Clear-enable command clears the latch
// - Status read shifts status out
// - Status write changes only lock and selects
// - Memory read loads address, outputs addressed byte
// - Read address advances every eight clocks
// - Read address wraps past highest address
// - Write: opcode, address, data until deselect
// - Write address advances per byte, wraps
// - Protect selects cover quarter, half, all
// - Hardware protection keeps protect selects unchanged
`timescale 1ns/10ps
`default_nettype none
module sfc_top (
    input  wire logic clock_i,
    input  wire logic reset_i,
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic si_i,
    input  wire logic pause_n_i,
    input  wire logic wp_n_i,
    output var  logic so_o,
    output var  logic so_oe_o
);
    import sfc_pkg::*;

    // Protection decode of the block select bits against a cell address
    function automatic logic is_protected(input logic [1:0] sel, input logic [MEM_AW-1:0] adr);
        case (sel)
            2'b01:   is_protected = (adr[MEM_AW-1:MEM_AW-2] == 2'b11);
            2'b10:   is_protected = adr[MEM_AW-1];
            2'b11:   is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    endfunction : is_protected

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling: two flops per pin, only the second is looked at
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic              sck_prev_q;
    logic              cs_n_s;
    logic              sck_s;
    logic              si_s;
    logic              pause_n_s;
    logic              wp_n_s;
    logic              sck_rise;
    logic              sck_fall;

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sync1_q    <= 5'h1_9;
            sync2_q    <= 5'h1_9;
            sck_prev_q <= 1'b0;
        end else begin
            sync1_q    <= {wp_n_i, pause_n_i, si_i, sck_i, cs_n_i};
            sync2_q    <= sync1_q;
            sck_prev_q <= sync2_q[PIN_SCK];
        end
    end

    assign cs_n_s    = sync2_q[PIN_CS];
    assign sck_s     = sync2_q[PIN_SCK];
    assign si_s      = sync2_q[PIN_SI];
    assign pause_n_s = sync2_q[PIN_PAUSE];
    assign wp_n_s    = sync2_q[PIN_WP];
    // Either clock idle level works since only edges matter
    assign sck_rise  = sck_s & ~sck_prev_q;
    assign sck_fall  = ~sck_s & sck_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Protocol state, status fields and output shifter
    sfc_state_e         st_q, st_d;
    logic [2:0]         bit_q, bit_d;
    logic [6:0]         sin_q, sin_d;
    logic               abyte_q, abyte_d;
    logic               rd_q, rd_d;
    logic [SPI_AW-1:0]  adr_q, adr_d;
    logic [7:0]         out_q, out_d;
    logic               so_q, so_d;
    logic               write_enable_latch_q, write_enable_latch_d;
    logic               protect_sel0_q, protect_sel0_d;
    logic               protect_sel1_q, protect_sel1_d;
    logic               status_lock_q, status_lock_d;
    logic               wpend_q, wpend_d;
    logic [MEM_AW-1:0]  wadr_q, wadr_d;
    logic [7:0]         wdat_q, wdat_d;
    logic [7:0]         byte_v;
    logic [7:0]         status_v;
    logic [MEM_AW-1:0]  cell_v;
    logic               hard_protect;
    logic               fetch;
    logic               push_rdy;
    logic [7:0]         mem_q [MEM_DEPTH];

    // Status image: unused bits and the in-progress flag read zero
    always_comb begin
        status_v                      = 8'h00;
        status_v[STAT_IN_PROGRESS_BIT] = 1'b0;
        status_v[STAT_WEL_BIT]        = write_enable_latch_q;
        status_v[STAT_SEL0_BIT]       = protect_sel0_q;
        status_v[STAT_SEL1_BIT]       = protect_sel1_q;
        status_v[STAT_LOCK_BIT]       = status_lock_q;
    end

    assign hard_protect = ~wp_n_s & status_lock_q;
    assign byte_v       = {sin_q, si_s};

    // Next values of the command sequencer
    always_comb begin
        st_d                 = st_q;
        bit_d                = bit_q;
        sin_d                = sin_q;
        abyte_d              = abyte_q;
        rd_d                 = rd_q;
        adr_d                = adr_q;
        out_d                = out_q;
        so_d                 = so_q;
        write_enable_latch_d = write_enable_latch_q;
        protect_sel0_d       = protect_sel0_q;
        protect_sel1_d       = protect_sel1_q;
        status_lock_d        = status_lock_q;
        wpend_d              = wpend_q & ~push_rdy;
        wadr_d               = wadr_q;
        wdat_d               = wdat_q;
        fetch                = 1'b0;
        cell_v               = adr_q[MEM_AW-1:0];
        if (cs_n_s) begin
            // Deselect ends any command; next select starts afresh
            st_d    = ST_OPC;
            bit_d   = 3'h0;
            abyte_d = 1'b0;
        end else if (pause_n_s) begin
            if (sck_rise) begin
                sin_d = byte_v[6:0];
                bit_d = bit_q + 3'h1;
                if (bit_q == 3'h7) begin
                    case (st_q)
                        ST_OPC: begin
                            case (byte_v)
                                OPC_SET_WE: begin
                                    write_enable_latch_d = 1'b1;
                                    st_d = ST_IGNORE;
                                end
                                OPC_CLR_WE: begin
                                    write_enable_latch_d = 1'b0;
                                    st_d = ST_IGNORE;
                                end
                                OPC_STAT_RD: begin
                                    out_d = status_v;
                                    st_d  = ST_STAT_RD;
                                end
                                OPC_STAT_WR: st_d = ST_STAT_WR;
                                OPC_MEM_RD: begin
                                    rd_d = 1'b1;
                                    st_d = ST_ADDR;
                                end
                                OPC_MEM_WR: begin
                                    rd_d = 1'b0;
                                    st_d = ST_ADDR;
                                end
                                default: st_d = ST_IGNORE;
                            endcase
                        end
                        ST_ADDR: begin
                            abyte_d = ~abyte_q;
                            if (!abyte_q) begin
                                adr_d[15:8] = byte_v;
                            end else begin
                                adr_d[7:0] = byte_v;
                                cell_v     = {adr_q[11:8], byte_v};
                                if (rd_q) begin
                                    out_d = mem_q[cell_v];
                                    fetch = 1'b1;
                                    adr_d = {adr_q[15:8], byte_v} + 16'h0001;
                                    st_d  = ST_MEM_RD;
                                end else begin
                                    st_d  = ST_MEM_WR;
                                end
                            end
                        end
                        ST_MEM_RD: begin
                            // Twelve-bit cell index wraps by itself past the top
                            out_d = mem_q[cell_v];
                            fetch = 1'b1;
                            adr_d = adr_q + 16'h0001;
                        end
                        ST_MEM_WR: begin
                            if (write_enable_latch_q &&
                                !is_protected({protect_sel1_q, protect_sel0_q}, cell_v)) begin
                                wpend_d = 1'b1;
                                wadr_d  = cell_v;
                                wdat_d  = byte_v;
                            end
                            adr_d = adr_q + 16'h0001;
                        end
                        ST_STAT_RD: out_d = status_v;
                        ST_STAT_WR: begin
                            if (write_enable_latch_q && !hard_protect) begin
                                protect_sel0_d = byte_v[STAT_SEL0_BIT];
                                protect_sel1_d = byte_v[STAT_SEL1_BIT];
                                status_lock_d  = byte_v[STAT_LOCK_BIT];
                            end
                            st_d = ST_IGNORE;
                        end
                        ST_IGNORE: st_d = ST_IGNORE;
                        default:   st_d = ST_IGNORE;
                    endcase
                end
            end
            if (sck_fall) begin
                so_d  = out_q[7];
                out_d = {out_q[6:0], 1'b0};
            end
        end
    end

    // Register the sequencer; status is volatile and clears on reset
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_q                 <= ST_OPC;
            bit_q                <= 3'h0;
            sin_q                <= 7'h00;
            abyte_q              <= 1'b0;
            rd_q                 <= 1'b0;
            adr_q                <= 16'h0000;
            out_q                <= 8'h00;
            so_q                 <= 1'b0;
            write_enable_latch_q <= RST_WRITE_ENABLE;
            protect_sel0_q       <= RST_PROTECT_SEL;
            protect_sel1_q       <= RST_PROTECT_SEL;
            status_lock_q        <= RST_STATUS_LOCK;
            wpend_q              <= 1'b0;
            wadr_q               <= 12'h000;
            wdat_q               <= 8'h00;
        end else begin
            st_q                 <= st_d;
            bit_q                <= bit_d;
            sin_q                <= sin_d;
            abyte_q              <= abyte_d;
            rd_q                 <= rd_d;
            adr_q                <= adr_d;
            out_q                <= out_d;
            so_q                 <= so_d;
            write_enable_latch_q <= write_enable_latch_d;
            protect_sel0_q       <= protect_sel0_d;
            protect_sel1_q       <= protect_sel1_d;
            status_lock_q        <= status_lock_d;
            wpend_q              <= wpend_d;
            wadr_q               <= wadr_d;
            wdat_q               <= wdat_d;
        end
    end

    // Output drives only while selected, unpaused and in a read phase
    assign so_o    = so_q;
    assign so_oe_o = ~cs_n_s & pause_n_s & ((st_q == ST_MEM_RD) | (st_q == ST_STAT_RD));

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry write buffer between byte assembly and the array.
    // The array has one port; a read fetch takes it and stalls the drain.
    logic [MEM_AW+7:0] ent_q [2];
    logic [MEM_AW+7:0] ent_d [2];
    logic              wptr_q, wptr_d;
    logic              rptr_q, rptr_d;
    logic [1:0]        cnt_q, cnt_d;
    logic              pop;

    assign push_rdy = (cnt_q != 2'h2);
    assign pop      = (cnt_q != 2'h0) & ~fetch;

    // Next values of the buffer pointers and entries
    always_comb begin
        ent_d  = ent_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d  = cnt_q;
        if (wpend_q && push_rdy) begin
            ent_d[wptr_q] = {wadr_q, wdat_q};
            wptr_d        = ~wptr_q;
        end
        if (pop) begin
            rptr_d = ~rptr_q;
        end
        cnt_d = cnt_q + {1'b0, wpend_q & push_rdy} - {1'b0, pop};
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ent_q[0] <= 20'h0_0000;
            ent_q[1] <= 20'h0_0000;
            wptr_q   <= 1'b0;
            rptr_q   <= 1'b0;
            cnt_q    <= 2'h0;
        end else begin
            ent_q    <= ent_d;
            wptr_q   <= wptr_d;
            rptr_q   <= rptr_d;
            cnt_q    <= cnt_d;
        end
    end

    // Array cells are nonvolatile and so take no reset
    always_ff @(posedge clock_i) begin
        if (pop) begin
            mem_q[ent_q[rptr_q][MEM_AW+7:8]] <= ent_q[rptr_q][7:0];
        end
    end

endmodule : sfc_top
`default_nettype wire

// [tb/sfc_top_sva.sv]
// Pin-level checker for the serial memory command slave
`timescale 1ns/10ps
`default_nettype none
module sfc_chk
    import sfc_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic pause_n_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_o
);
    logic       sck_q;
    logic [5:0] cnt_q, cnt_d;
    logic [7:0] opc_q, opc_d;
    ////////////////////////////////////////////////////////////
    // Count clock rises in a frame; saturates so a long read never falls back under 24
    always_comb begin
        cnt_d = cnt_q;
        opc_d = opc_q;
        if (cs_n_i) begin
            cnt_d = 6'h00;
        end else if (sck_i && !sck_q && pause_n_i) begin
            if (cnt_q < 6'h08) opc_d = {opc_q[6:0], si_i};
            if (cnt_q != 6'h3F) cnt_d = cnt_q + 6'h01;
        end
    end
    // Register the frame tracker
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sck_q <= 1'b0;
            cnt_q <= 6'h00;
            opc_q <= 8'h00;
        end else begin
            sck_q <= sck_i;
            cnt_q <= cnt_d;
            opc_q <= opc_d;
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    a_reset_quiet: assert property ($fell(reset_i) |-> !so_oe_o && !so_o)
        else $error("output active right after reset");
    a_desel_off: assert property (cs_n_i [*4] |-> !so_oe_o)
        else $error("output driven while deselected");
    a_pause_off: assert property (!pause_n_i [*4] |-> !so_oe_o)
        else $error("output driven while paused");
    a_so_steady: assert property ((sck_i && !cs_n_i && pause_n_i) [*8] |=> $stable(so_o))
        else $error("output changed while clock high");
    a_opc_first: assert property (!cs_n_i && so_oe_o |-> cnt_q >= 6'h08)
        else $error("output driven before opcode complete");
    a_stat_drive: assert property ($rose(cnt_q == 6'h08) && opc_q == OPC_STAT_RD |-> ##[1:8] so_oe_o)
        else $error("status read did not drive output");
    a_read_drive: assert property ($rose(cnt_q == 6'h18) && opc_q == OPC_MEM_RD |-> ##[1:8] so_oe_o)
        else $error("memory read did not drive output");
    a_read_wait: assert property (!cs_n_i && so_oe_o && opc_q == OPC_MEM_RD |-> cnt_q >= 6'h18)
        else $error("memory read drove output before address");
    a_quiet_other: assert property (cnt_q >= 6'h08 && opc_q != OPC_STAT_RD && opc_q != OPC_MEM_RD |-> !so_oe_o)
        else $error("output driven for a non-read opcode");
    c_stat_read: cover property ($rose(cnt_q == 6'h08) && opc_q == OPC_STAT_RD);
    c_mem_read: cover property (so_oe_o && opc_q == OPC_MEM_RD);
    c_pause: cover property (!cs_n_i && !pause_n_i);
endmodule : sfc_chk
`default_nettype wire

// [tb/sfc_host_model.sv]
// Host controller model framing commands on the serial pins
`timescale 1ns/10ps
`default_nettype none
module sfc_host_model #(
    parameter realtime HALF_NS = 62.5,
    parameter realtime SKEW_NS = 0.25
) (
    input  wire logic clock_i,
    input  wire logic so_i,
    output var  logic cs_n_o,
    output var  logic sck_o,
    output var  logic si_o
);
    logic mode3 = 1'b0;
    // Deselected with clock parked low at start
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // Step a quarter past a falling edge; every later half period then stays
    // clear of a rising edge, so no pin ever races the sampling flops
    task automatic align();
        @(negedge clock_i);
        #SKEW_NS;
    endtask : align
    // Park clock at the idle level of the mode, then select
    task automatic start(input logic m3);
        align();
        mode3 = m3;
        sck_o = m3;
        #HALF_NS cs_n_o = 1'b0;
        #HALF_NS;
    endtask : start
    // One byte, most significant bit first; data set on fall, read on rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_o = 1'b0;
            si_o  = tx[i];
            #HALF_NS sck_o = 1'b1;
            rx[i] = so_i;
            #HALF_NS;
        end
    endtask : xfer
    // Back to idle level; data line flips so no stale bit lingers
    task automatic stop();
        sck_o = mode3;
        #HALF_NS cs_n_o = 1'b1;
        si_o = ~si_o;
        #(4 * HALF_NS);
    endtask : stop
    // Noise on clock and data during pause, select kept low; even count keeps the level
    task automatic wiggle(input int n);
        align();
        repeat (n) begin
            #HALF_NS sck_o = ~sck_o;
            si_o = ~si_o;
        end
        #HALF_NS;
    endtask : wiggle
endmodule : sfc_host_model
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the serial memory command slave
`timescale 1ns/10ps
`default_nettype none
module tb;
    import sfc_pkg::*;
    typedef struct packed {logic m3; logic [7:0] op; logic [7:0] dat; logic [7:0] st;} sfc_row_s;
    logic       clock_i   = 1'b0;
    logic       reset_i   = 1'b1;
    logic       pause_n_i = 1'b1;
    logic       wp_n_i    = 1'b1;
    logic       so_o;
    logic       so_oe_o;
    wire logic  cs_n;
    wire logic  sck;
    wire logic  si;
    wire logic  so_line;
    logic [7:0] rx;
    logic [7:0] stat_exp = 8'h00;
    logic [7:0] mem_exp [4096];
    int         errors = 0;
    int         samples_checked = 0;
    logic [15:0] probes [3] = '{16'h07FF, 16'h0BFF, 16'h0FFF};
    // Command, its data byte, then the status it must leave behind
    sfc_row_s rows [9] = '{'{1'b0, OPC_SET_WE, 8'h00, 8'h02}, '{1'b1, OPC_CLR_WE, 8'h00, 8'h00},
        '{1'b0, OPC_STAT_WR, 8'hFF, 8'h00}, '{1'b1, OPC_SET_WE, 8'h00, 8'h02},
        '{1'b0, OPC_STAT_WR, 8'hFF, 8'h8E}, '{1'b1, OPC_STAT_WR, 8'h00, 8'h02},
        '{1'b0, OPC_CLR_WE, 8'h00, 8'h00}, '{1'b1, 8'hFF, OPC_SET_WE, 8'h00},
        '{1'b0, OPC_SET_WE, 8'h00, 8'h02}};
    ////////////////////////////////////////////////////////////
    // Released output line floats; a bit read from it never matches
    assign so_line = so_oe_o ? so_o : 1'bz;
    always #2 clock_i = ~clock_i;
    sfc_host_model host (.clock_i(clock_i), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    sfc_top dut (.clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .pause_n_i(pause_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o));
    ////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask : chk1
    function automatic logic prot(input logic [1:0] s, input logic [11:0] c);
        return (s == 2'h3) || (s == 2'h2 && c >= 12'h800) || (s == 2'h1 && c >= 12'hC00);
    endfunction : prot
    task automatic cmd(input logic m3, input logic [7:0] op, input logic [7:0] d);
        host.start(m3);
        host.xfer(op, rx);
        host.xfer(d, rx);
        host.stop();
    endtask : cmd
    // Status read, two bytes to see it repeat
    task automatic stat(input logic m3, input logic [7:0] exp);
        host.start(m3);
        host.xfer(OPC_STAT_RD, rx);
        repeat (2) begin
            host.xfer(8'h00, rx);
            chk8(rx, exp);
        end
        host.stop();
    endtask : stat
    // Write n bytes d, d+1..; the model drops what the latch or the protect area refuses
    task automatic mwr(input logic [15:0] a, input logic [7:0] d, input int n);
        logic [11:0] c;
        host.start(1'b0);
        host.xfer(OPC_MEM_WR, rx);
        host.xfer(a[15:8], rx);
        host.xfer(a[7:0], rx);
        for (int i = 0; i < n; i++) begin
            c = a[11:0] + i[11:0];
            host.xfer(d + i[7:0], rx);
            if (stat_exp[1] && !prot(stat_exp[3:2], c)) mem_exp[c] = d + i[7:0];
        end
        host.stop();
    endtask : mwr
    task automatic mrd(input logic [15:0] a, input int n);
        host.start(1'b1);
        host.xfer(OPC_MEM_RD, rx);
        host.xfer(a[15:8], rx);
        host.xfer(a[7:0], rx);
        for (int i = 0; i < n; i++) begin
            host.xfer(8'h00, rx);
            chk8(rx, mem_exp[a[11:0] + i[11:0]]);
        end
        host.stop();
    endtask : mrd
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////
    // Main sequence: reset, command table, then boundary cases
    initial begin
        repeat (10) @(posedge clock_i);
        @(negedge clock_i) reset_i = 1'b0;
        repeat (4) @(negedge clock_i);
        chk1(so_oe_o, 1'b0);
        stat(1'b0, 8'h00);
        foreach (rows[k]) begin
            cmd(rows[k].m3, rows[k].op, rows[k].dat);
            stat_exp = rows[k].st;
            stat(rows[k].m3, stat_exp);
        end
        mwr(16'hFFFE, 8'h10, 3);
        mrd(16'hAFFE, 3);
        for (int s = 0; s < 4; s++) begin
            cmd(1'b0, OPC_STAT_WR, {4'h0, s[1:0], 2'h0});
            stat_exp = {4'h0, s[1:0], 2'h2};
            stat(1'b0, stat_exp);
            foreach (probes[p]) begin
                mwr(probes[p], {s[1:0], probes[p][11:8], 2'h0}, 2);
                mrd(probes[p], 2);
            end
        end
        cmd(1'b0, OPC_STAT_WR, 8'h84);
        stat(1'b0, 8'h86);
        @(negedge clock_i) wp_n_i = 1'b0;
        cmd(1'b1, OPC_STAT_WR, 8'h00);
        stat(1'b1, 8'h86);
        @(negedge clock_i) wp_n_i = 1'b1;
        cmd(1'b0, OPC_STAT_WR, 8'h00);
        stat(1'b0, 8'h02);
        cmd(1'b0, OPC_CLR_WE, 8'h00);
        stat_exp = 8'h00;
        mwr(16'h07FF, 8'hEE, 1);
        mrd(16'h07FF, 1);
        host.start(1'b0);
        host.xfer(OPC_MEM_RD, rx);
        host.xfer(8'h07, rx);
        host.xfer(8'hFF, rx);
        host.xfer(8'h00, rx);
        chk8(rx, mem_exp[12'h7FF]);
        @(negedge clock_i) pause_n_i = 1'b0;
        host.wiggle(4);
        chk1(so_oe_o, 1'b0);
        @(negedge clock_i) pause_n_i = 1'b1;
        repeat (8) @(negedge clock_i);
        chk1(so_oe_o, 1'b1);
        // Resume off the rising edge before clocking again
        host.align();
        host.xfer(8'h00, rx);
        chk8(rx, mem_exp[12'h800]);
        host.stop();
        chk1(so_oe_o, 1'b0);
        end_of_test();
    end
    // Bound on the whole run
    initial begin
        repeat (90000) @(posedge clock_i);
        errors++;
        end_of_test();
    end
endmodule : tb
bind sfc_top sfc_chk chk (.clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .si_i(si_i), .pause_n_i(pause_n_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o));
`default_nettype wire
